// ---- bus_cycle_pkg.sv ----
// Shared types, constants and helpers for the pipelined bus-cycle state machine.
// Assumes a single clock domain; pin inputs are synchronised inside the block.
`default_nettype none

package bus_cycle_pkg;

    // ------------------------------------------------------------------
    // Bus states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        idle_state,
        hold_granted_state,
        first_state,
        second_state,
        first_pipelined_state,
        pipelined_next_state,
        pipelined_idle_request_state
    } bus_state_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // Address and cycle definition as presented on the bus.
    typedef struct packed {
        logic [29:0] word_address;
        logic [3:0]  byte_lane_select_n;
        logic        write;
        logic        data_ctrl;
        logic        mem_io;
    } cycle_def_t;

    // One internal bus request with its write data.
    typedef struct packed {
        cycle_def_t  def;
        logic [31:0] write_data;
    } bus_req_t;

    // Every pin input that passes the two-stage synchroniser.
    typedef struct packed {
        logic        ready_n;
        logic        next_addr_request_n;
        logic        half_width_select_n;
        logic        hold;
        logic        clock_doubled;
        logic [31:0] data;
    } pin_sample_t;

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    localparam logic [3:0]  LANES_NONE_N     = 4'hF;
    localparam logic [1:0]  LOW_LANES_OFF_N  = 2'h3;
    localparam logic        PHASE_ONE        = 1'h0;
    localparam logic [31:0] DATA_RESET       = 32'h0000_0000;
    localparam cycle_def_t  CYCLE_DEF_RESET  = '{30'h0000_0000, LANES_NONE_N, 1'h0, 1'h0, 1'h0};
    localparam bus_req_t    BUS_REQ_RESET    = '{CYCLE_DEF_RESET, DATA_RESET};
    localparam pin_sample_t PIN_SAMPLE_RESET = '{1'h1, 1'h1, 1'h1, 1'h0, 1'h0, DATA_RESET};

    // ------------------------------------------------------------------
    // Lane decoding
    // ------------------------------------------------------------------
    // True when lanes 1 and 2 are both selected, so a half-width transfer splits.
    function automatic logic needs_split(input logic [3:0] lanes_n);
        return !lanes_n[1] && !lanes_n[2];
    endfunction

    // True when neither low lane is selected: data travels on the low lines.
    function automatic logic low_lanes_off(input logic [3:0] lanes_n);
        return lanes_n[1:0] == LOW_LANES_OFF_N;
    endfunction

endpackage

`default_nettype wire

// ---- pipelined_cpu_bus_cycle_fsm.sv ----
// Bus-cycle state machine of a processor local bus with address pipelining
// and a half-width data mode.
// Assumes the bus pins arrive asynchronously and that the internal requester
// runs on CLK_IN and drops or replaces its request after REQ_TAKEN_OUT.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - Second state acts on next-address only when waiting
// - Accepted pipelining drives next address with strobe
// - Shortest pipelined cycle is two states
// - First pipelined state follows end of cycle
// - First pipelined state branches on request, pending
// - Pipelined cycle ends only after first pipelined state
// - Reads float data, latch at acknowledge
// - Pipelined write data driven phase two, held
// - Pipelined wait states repeat without limit
// - Pending cycle stays valid; repeats ignored
// - Missing request in first pipelined state gives idle-request
// - Pending arising in idle-request moves to pipelined-next
// - First cycle after reset/idle/hold nonpipelined
// - Next-address sampled after one valid state
// - Pipelining continues only when ending in pipelined-next
// - Distinct idle-request and next states
// - Half width uses low lines, extra cycles
// - Upper-lanes-only uses low lines, no split
// - Split reads take two low-line cycles
// - Split writes send low then high pair
// - Simultaneous half-width wins over next-address
// - Acknowledge without request goes idle or hold
// - Bus state is one internal clock
module pipelined_cpu_bus_cycle_fsm
    import bus_cycle_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RESET_IN,
    input  wire logic        READY_N_IN,
    input  wire logic        NEXT_ADDR_REQUEST_N_IN,
    input  wire logic        HALF_WIDTH_SELECT_N_IN,
    input  wire logic        HOLD_IN,
    input  wire logic        CLOCK_DOUBLED_IN,
    input  wire logic [31:0] DATA_IN,
    input  wire logic        REQ_VALID_IN,
    input  wire bus_req_t    REQ_IN,
    output logic             REQ_TAKEN_OUT,
    output logic             ADDR_VALID_STROBE_N_OUT,
    output var cycle_def_t   CYCLE_OUT,
    output logic [31:0]      DATA_OUT,
    output logic             DATA_OE_OUT,
    output logic             HOLD_GRANT_OUT,
    output logic [31:0]      READ_DATA_OUT,
    output logic             CYCLE_DONE_OUT,
    output var bus_state_t   BUS_STATE_OUT
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    pin_sample_t pin_meta;
    pin_sample_t pin_sync;
    bus_state_t  state;
    bus_state_t  next_state;
    bus_state_t  finish_state;
    bus_req_t    cur;
    bus_req_t    nxt;
    cycle_def_t  next_def;
    logic        phase;
    logic        doubled;
    logic        ph_one_end;
    logic        state_end;
    logic        ack_state;
    logic        req_pending;
    logic        nreq_now;
    logic        half_now;
    logic        half_eff;
    logic        nreq_cycle;
    logic        part_two;
    logic        split_now;
    logic        enter_first;
    logic        enter_pn;
    logic        take_req;
    logic        in_sampling;
    logic        data_hold;
    logic        start_drive;

    // ------------------------------------------------------------------
    // Pin synchroniser
    // ------------------------------------------------------------------
    // Two stages on every pin; only the second stage is read by logic.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            pin_meta <= PIN_SAMPLE_RESET;
            pin_sync <= PIN_SAMPLE_RESET;
        end else begin
            pin_meta <= '{READY_N_IN, NEXT_ADDR_REQUEST_N_IN, HALF_WIDTH_SELECT_N_IN,
                          HOLD_IN, CLOCK_DOUBLED_IN, DATA_IN};
            pin_sync <= pin_meta;
        end
    end

    // ------------------------------------------------------------------
    // Internal processor clock phases
    // ------------------------------------------------------------------
    // A bus state is two input clocks normally and one when doubled; in
    // doubled mode both phase boundaries fall on every edge.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            phase <= PHASE_ONE;
        end else if (doubled) begin
            phase <= PHASE_ONE;
        end else begin
            phase <= !phase;
        end
    end

    assign doubled    = pin_sync.clock_doubled;
    assign ph_one_end = doubled || (phase == PHASE_ONE);
    assign state_end  = doubled || (phase != PHASE_ONE);

    // ------------------------------------------------------------------
    // Decode of the current state
    // ------------------------------------------------------------------
    // The pending flag masks the cycle right after a take, because the
    // requester only sees the take one clock later.
    assign req_pending = REQ_VALID_IN && !REQ_TAKEN_OUT;
    assign ack_state   = !pin_sync.ready_n && (state == second_state ||
                         state == pipelined_next_state || state == pipelined_idle_request_state);
    assign half_eff    = half_now && !nreq_cycle;
    assign split_now   = ack_state && half_eff && !part_two &&
                         needs_split(cur.def.byte_lane_select_n);
    assign in_sampling = !nreq_cycle && (state == second_state || state == first_pipelined_state ||
                         state == pipelined_idle_request_state);
    assign enter_first = next_state == first_state && state != first_state;
    assign enter_pn    = next_state == pipelined_next_state && state != pipelined_next_state;
    assign take_req    = enter_pn || (enter_first && !split_now);

    // After acknowledgement: the split half, a new request, hold or idle.
    always_comb begin
        if (split_now || req_pending) begin
            finish_state = first_state;
        end else if (pin_sync.hold) begin
            finish_state = hold_granted_state;
        end else begin
            finish_state = idle_state;
        end
    end

    // Bus state transitions, evaluated for the edge that ends a state.
    always_comb begin
        next_state = state;
        case (state)
            idle_state: begin
                if (req_pending) begin
                    next_state = first_state;
                end else if (pin_sync.hold) begin
                    next_state = hold_granted_state;
                end
            end
            hold_granted_state: begin
                if (!pin_sync.hold) begin
                    next_state = req_pending ? first_state : idle_state;
                end
            end
            first_state: begin
                next_state = second_state;
            end
            second_state: begin
                if (ack_state) begin
                    next_state = finish_state;
                end else if (nreq_now && req_pending) begin
                    next_state = pipelined_next_state;
                end else if (nreq_now) begin
                    next_state = pipelined_idle_request_state;
                end
            end
            first_pipelined_state: begin
                if (!req_pending) begin
                    next_state = pipelined_idle_request_state;
                end else if (nreq_now) begin
                    next_state = pipelined_next_state;
                end else begin
                    next_state = second_state;
                end
            end
            pipelined_next_state: begin
                if (ack_state) begin
                    next_state = first_pipelined_state;
                end
            end
            pipelined_idle_request_state: begin
                if (ack_state) begin
                    next_state = finish_state;
                end else if (req_pending) begin
                    next_state = pipelined_next_state;
                end
            end
            default: begin
                next_state = idle_state;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    // Without acknowledgement, next-address or a pending request the waiting states simply hold.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            state <= idle_state;
        end else if (state_end) begin
            state <= next_state;
        end
    end

    assign BUS_STATE_OUT = state;

    // ------------------------------------------------------------------
    // Next-address and half-width sampling
    // ------------------------------------------------------------------
    // Sampled where phase one ends. Half width in the same window cancels
    // the next-address request; once a pipelined state was reached in the
    // cycle, later requests and half width are both ignored.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            nreq_now   <= 1'h0;
            half_now   <= 1'h0;
            nreq_cycle <= 1'h0;
        end else begin
            if (ph_one_end) begin
                nreq_now <= in_sampling && !pin_sync.next_addr_request_n &&
                            pin_sync.half_width_select_n;
                half_now <= !pin_sync.half_width_select_n;
            end
            if (state_end && ack_state) begin
                nreq_cycle <= 1'h0;
            end else if (state_end && (enter_pn || next_state == pipelined_idle_request_state)) begin
                nreq_cycle <= 1'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Cycle and look-ahead request registers
    // ------------------------------------------------------------------
    // The second half of a split keeps the address and write data and only
    // negates the low lanes.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            cur      <= BUS_REQ_RESET;
            nxt      <= BUS_REQ_RESET;
            part_two <= 1'h0;
        end else if (state_end) begin
            if (ack_state) begin
                part_two <= 1'h0;
            end
            if (enter_first && split_now) begin
                cur.def.byte_lane_select_n[1:0] <= LOW_LANES_OFF_N;
                part_two                        <= 1'h1;
            end else if (enter_first) begin
                cur <= REQ_IN;
            end
            if (enter_pn) begin
                nxt <= REQ_IN;
            end
            if (state == pipelined_next_state && ack_state) begin
                cur <= nxt;
            end
        end
    end

    // ------------------------------------------------------------------
    // Address, cycle definition and strobe outputs
    // ------------------------------------------------------------------
    always_comb begin
        next_def = REQ_IN.def;
        if (split_now) begin
            next_def                         = cur.def;
            next_def.byte_lane_select_n[1:0] = LOW_LANES_OFF_N;
        end
    end

    // Address and cycle definition change only when a new cycle is presented, so an idle-request
    // state leaves the old address standing.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            ADDR_VALID_STROBE_N_OUT <= 1'h1;
            CYCLE_OUT               <= CYCLE_DEF_RESET;
            HOLD_GRANT_OUT          <= 1'h0;
            REQ_TAKEN_OUT           <= 1'h0;
        end else begin
            REQ_TAKEN_OUT <= state_end && take_req;
            if (state_end) begin
                ADDR_VALID_STROBE_N_OUT <= !(next_state == first_state ||
                                             next_state == pipelined_next_state);
                HOLD_GRANT_OUT          <= next_state == hold_granted_state;
                if (enter_first || enter_pn) begin
                    CYCLE_OUT <= next_def;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Write data drive
    // ------------------------------------------------------------------
    // Drive starts at phase two of the first state of a write and lasts
    // through phase one of the state after acknowledgement for hold time.
    assign start_drive = ph_one_end && cur.def.write &&
                         (state == first_state || state == first_pipelined_state);

    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            DATA_OUT    <= DATA_RESET;
            DATA_OE_OUT <= 1'h0;
            data_hold   <= 1'h0;
        end else begin
            if (start_drive) begin
                DATA_OE_OUT <= 1'h1;
                if (low_lanes_off(cur.def.byte_lane_select_n)) begin
                    DATA_OUT <= {cur.write_data[31:16], cur.write_data[31:16]};
                end else begin
                    DATA_OUT <= cur.write_data;
                end
            end else if (ph_one_end && data_hold) begin
                DATA_OE_OUT <= 1'h0;
            end
            if (state_end && ack_state && cur.def.write) begin
                data_hold <= 1'h1;
            end else if (ph_one_end) begin
                data_hold <= 1'h0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data capture and completion
    // ------------------------------------------------------------------
    // In half-width mode only the low lines count; the upper lines are
    // ignored and the result is assembled over the split halves.
    always_ff @(posedge CLK_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            READ_DATA_OUT  <= DATA_RESET;
            CYCLE_DONE_OUT <= 1'h0;
        end else begin
            CYCLE_DONE_OUT <= state_end && ack_state && !split_now;
            if (state_end && ack_state && !cur.def.write) begin
                if (!half_eff) begin
                    READ_DATA_OUT <= pin_sync.data;
                end else if (low_lanes_off(cur.def.byte_lane_select_n)) begin
                    READ_DATA_OUT[31:16] <= pin_sync.data[15:0];
                end else begin
                    READ_DATA_OUT[15:0] <= pin_sync.data[15:0];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (RESET_IN);

    pipe_ready_ignored_a: assert property (
        state == first_pipelined_state && state_end |=> state != first_pipelined_state &&
        state != idle_state && state != first_state) else $error("First pipelined state ended on acknowledge.");

    pipe_entry_a: assert property (
        state == first_pipelined_state && $past(state) != first_pipelined_state
        |-> $past(state) == pipelined_next_state) else $error("First pipelined state entered wrongly.");

    next_strobe_a: assert property (
        state == pipelined_next_state |-> !ADDR_VALID_STROBE_N_OUT) else $error("Pipelined-next without strobe.");

    idle_req_quiet_a: assert property (
        state == pipelined_idle_request_state && $past(state) == pipelined_idle_request_state
        |-> ADDR_VALID_STROBE_N_OUT && $stable(CYCLE_OUT)) else $error("Idle-request changed the address.");

    idle_exit_a: assert property (
        state == idle_state ##1 state != idle_state
        |-> state == first_state || state == hold_granted_state) else $error("Pipelined start after idle.");

    next_waits_a: assert property (
        state == pipelined_next_state && state_end && pin_sync.ready_n
        |=> state == pipelined_next_state) else $error("Pipelined-next wait state not repeated.");

    read_float_a: assert property (
        (state == second_state || state == pipelined_next_state) && !cur.def.write
        && $past(state) == state |-> !DATA_OE_OUT) else $error("Data driven during read.");

    write_drive_a: assert property (
        start_drive |=> DATA_OE_OUT [*2]) else $error("Write data not driven.");

    split_lanes_a: assert property (
        state_end && split_now |=> ADDR_VALID_STROBE_N_OUT == 1'h0 ##0
        CYCLE_OUT.byte_lane_select_n[1:0] == LOW_LANES_OFF_N) else $error("Split part two lanes wrong.");

endmodule

`default_nettype wire

// ---- bus_responder.sv ----
// Behavioural system logic on the far side of the bus-cycle block.
// Assumes it watches the block's bus state and presented cycle on one clock.
`timescale 1ns/100ps
`default_nettype none
module bus_responder
    import bus_cycle_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       half_mode_in,
    input  wire bus_state_t state_in,
    input  wire cycle_def_t cycle_in,
    output var logic        ready_n_out = 1'h1,
    output var logic        next_addr_request_n_out = 1'h1,
    output var logic [31:0] data_out = 32'h0,
    output logic            half_width_select_n_out
);
    cycle_def_t  cur = CYCLE_DEF_RESET;
    logic [31:0] w;
    logic [15:0] sel;
    int          seed = 32'h681b;
    int          gap = 0;
    logic        next_used = 1'h0;
    // Read data is a fixed function of the word address, low or high half on the low lines.
    assign w = {cur.word_address, 2'h0} ^ 32'h5A3C_96E1;
    assign sel = (cur.byte_lane_select_n[1:0] == 2'h3) ? w[31:16] : w[15:0];
    assign half_width_select_n_out = !half_mode_in;
    // The gap keeps one acknowledge pulse from ever ending two cycles, despite the pin latency.
    always @(posedge clk_in) begin
        if (state_in == first_state || state_in == first_pipelined_state) begin
            cur <= cycle_in;
        end
        gap <= (gap > 0) ? gap - 1 : 0;
        ready_n_out <= 1'h1;
        data_out <= ~data_out;
        if (gap == 0 && state_in inside {second_state, pipelined_next_state, pipelined_idle_request_state}
            && $random(seed) % 3 == 0) begin
            ready_n_out <= 1'h0;
            data_out <= half_mode_in ? {~sel, sel} : w;
            gap <= 5;
            next_used <= 1'h0;
        end
        next_addr_request_n_out <= 1'h1;
        if (!next_used && state_in != idle_state && state_in != hold_granted_state && $random(seed) % 4 == 0) begin
            next_addr_request_n_out <= 1'h0;
            next_used <= 1'h1;
        end
    end
endmodule
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench: random requests against a queue model of the bus cycles.
// Assumes bus_cycle_pkg and bus_responder are compiled before it.
`timescale 1ns/100ps
`default_nettype none
module tb
    import bus_cycle_pkg::*;
;
    localparam logic [39:0] LANE_TABLE = 40'hEDB7C93810;
    logic        clk, reset, ready_n, nxt_req_n, half_n, hold, doubled, half, req_valid;
    logic        taken, strobe_n, oe, grant, done;
    logic [31:0] din, dout, rdata;
    bus_req_t    req;
    cycle_def_t  cyc;
    bus_state_t  state, prev;
    bus_req_t    q[$];
    int          seed, ops_left, n_pipe, n_fail, checks_done;
    pipelined_cpu_bus_cycle_fsm i_dut (.CLK_IN(clk), .RESET_IN(reset), .READY_N_IN(ready_n),
        .NEXT_ADDR_REQUEST_N_IN(nxt_req_n), .HALF_WIDTH_SELECT_N_IN(half_n), .HOLD_IN(hold),
        .CLOCK_DOUBLED_IN(doubled), .DATA_IN(din), .REQ_VALID_IN(req_valid), .REQ_IN(req),
        .REQ_TAKEN_OUT(taken), .ADDR_VALID_STROBE_N_OUT(strobe_n), .CYCLE_OUT(cyc), .DATA_OUT(dout),
        .DATA_OE_OUT(oe), .HOLD_GRANT_OUT(grant), .READ_DATA_OUT(rdata), .CYCLE_DONE_OUT(done),
        .BUS_STATE_OUT(state));
    bus_responder i_resp (.clk_in(clk), .half_mode_in(half), .state_in(state), .cycle_in(cyc),
        .ready_n_out(ready_n), .next_addr_request_n_out(nxt_req_n), .data_out(din), .half_width_select_n_out(half_n));
    // A 64-bit report serves every kind of compare.
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        check({32'h0, got}, {32'h0, exp});
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        check({63'h0, got}, {63'h0, exp});
    endtask
    task automatic cmp_def(input cycle_def_t got, input cycle_def_t exp);
        check({27'h0, got}, {27'h0, exp});
    endtask
    task automatic conclude();
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    function automatic logic [31:0] lane_mask(input logic [3:0] lanes_n);
        for (int b = 0; b < 4; b++) begin
            lane_mask[8*b +: 8] = {8{!lanes_n[b]}};
        end
    endfunction
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    // Completions are retired first, so a new cycle never checks against the finished one.
    always @(posedge clk) begin : model
        logic [31:0] m;
        logic [31:0] r;
        int          idx;
        bus_req_t    nr;
        if (reset) begin
            req_valid <= 1'h0;
            hold <= 1'h0;
            q.delete();
            cmp_flag(strobe_n, 1'h1);
        end else begin
            if (done && q.size() == 0) begin
                cmp_flag(done, 1'h0);
            end else if (done) begin
                m = lane_mask(q[0].def.byte_lane_select_n);
                if (!q[0].def.write) begin
                    cmp_word(rdata & m, ({q[0].def.word_address, 2'h0} ^ 32'h5A3C_96E1) & m);
                end
                void'(q.pop_front());
            end
            cmp_flag(strobe_n, !(state == first_state || state == pipelined_next_state));
            cmp_flag(grant, state == hold_granted_state);
            if (state == first_pipelined_state && prev != first_pipelined_state) begin
                cmp_flag(prev == pipelined_next_state, 1'h1);
            end
            if (state == pipelined_next_state) begin
                n_pipe++;
                cmp_flag(half, 1'h0);
            end
            if (q.size() > 0 && state inside {second_state, pipelined_next_state, pipelined_idle_request_state}) begin
                cmp_flag(oe, q[0].def.write);
                if (state == second_state && q[0].def.write) begin
                    m = lane_mask(cyc.byte_lane_select_n);
                    cmp_word(dout & m, q[0].write_data & m);
                    if (cyc.byte_lane_select_n[1:0] == 2'h3) begin
                        cmp_word({16'h0, dout[15:0]}, {16'h0, q[0].write_data[31:16]});
                    end
                end
            end
            if (taken) begin
                cmp_def(cyc, req.def);
                q.push_back(req);
            end
            if (ops_left > 0 && (!req_valid || taken) && $random(seed) % 3 != 0) begin
                r = $random(seed);
                idx = $unsigned($random(seed)) % 10;
                nr.def.word_address = r[29:0];
                nr.def.byte_lane_select_n = LANE_TABLE[4*idx +: 4];
                nr.def.write = r[31];
                nr.def.data_ctrl = r[30];
                nr.def.mem_io = idx[0];
                nr.write_data = $random(seed);
                req <= nr;
                req_valid <= 1'h1;
                ops_left--;
            end else if (taken) begin
                req_valid <= 1'h0;
            end
            hold <= ($random(seed) % 40 == 0) ? !hold : hold;
        end
        prev <= state;
    end
    // Four runs cover both widths in both clock modes, each opened by its own reset.
    initial begin
        seed = 32'h681b;
        reset = 1'h1;
        hold = 1'h0;
        doubled = 1'h0;
        half = 1'h0;
        req_valid = 1'h0;
        req = BUS_REQ_RESET;
        for (int ph = 0; ph < 4; ph++) begin
            reset <= 1'h1;
            half <= ph[0];
            doubled <= ph[1];
            repeat (12) @(posedge clk);
            reset <= 1'h0;
            ops_left = 40;
            for (int i = 0; i < 8000 && (ops_left > 0 || req_valid || q.size() > 0); i++) begin
                @(posedge clk);
            end
            if (ops_left > 0 || req_valid || q.size() > 0) begin
                n_fail++;
                conclude();
            end
        end
        cmp_flag(n_pipe > 0, 1'h1);
        conclude();
    end
endmodule
`default_nettype wire
